// ===== hw/vdc_top.v
// vdc_top.v: capture, passthrough and level decode front end of an
// 8-bit video DAC, with an Avalon-MM register slave.
// assumes all inputs synchronous to clk; convert_clock is sampled, not
// used as a clock, so it must run well below clk/2.
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "vdc_defs.vh"

// Functional notes
// - With passthrough low, data and controls are captured on each rising convert_clock edge while the buffer is not full, and only captured values drive the sinks.
// - With passthrough high, the capture stage is bypassed and the sinks follow the live inputs without any convert edge.
// - Passthrough is a mode level acting independently of convert_clock, meant to be held static by the source.
// - Data and control inputs left unused must be tied low at integration; low means inactive.
// - Sync selects the sync level whatever the data word and the other controls.
// - Blank without sync selects the blank level, ignoring data, force and brighten.
// - Force full scale without sync or blank replaces the data word by full scale.
// - Brighten without sync or blank adds a tenth of full scale to the selected level.
// - With no control active the data word maps linearly from the low to the high level.
// - Four video controls sync, blank, brighten and force full scale travel with the data word.
// - The upper data nibble becomes a fifteen-segment thermometer and the lower nibble drives binary weights.
module vdc_top (
  input  wire                    clk,
  input  wire                    reset,
  input  wire [`VDC_ADDR_W-1:0]  avs_address,
  input  wire                    avs_read,
  input  wire                    avs_write,
  input  wire [31:0]             avs_writedata,
  input  wire [3:0]              avs_byteenable,
  output reg  [31:0]             avs_readdata,
  output reg                     avs_waitrequest,
  input  wire                    convert_clock,
  input  wire                    passthrough_select,
  input  wire [`VDC_DATA_W-1:0]  data_word,
  input  wire                    sync,
  input  wire                    blank,
  input  wire                    force_full_scale,
  input  wire                    brighten,
  output reg                     pixel_ready,
  output reg                     pass_active,
  output reg  [`VDC_THERM_N-1:0] sink_therm,
  output reg  [`VDC_BIN_N-1:0]   sink_bin,
  output reg                     sink_blank,
  output reg                     sink_sync,
  output reg                     sink_bright
);

  // data_word[7] is data_bit_top, data_word[0] is data_bit_bottom

  // register state
  reg                    drain_hold;
  reg                    overflow;
  reg [`VDC_WORD_W-1:0]  held;
  reg                    cvt_prev;

  // bus handshake: one wait state on every access
  // offset match shared by the write strobes
  function addr_is(input [`VDC_ADDR_W-1:0] a,
                   input [`VDC_ADDR_W-1:0] off);
    begin
      addr_is = (a == off);
    end
  endfunction

  wire bus_req    = avs_read | avs_write;
  wire bus_take   = bus_req & ~avs_waitrequest;
  wire wr_take    = avs_write & ~avs_waitrequest;
  wire wr_ctrl    = wr_take & addr_is(avs_address, `VDC_REG_CTRL)
                    & avs_byteenable[0];
  wire wr_status  = wr_take & addr_is(avs_address, `VDC_REG_STATUS)
                    & avs_byteenable[0];

  // input word assembly
  // open inputs must be tied low at integration; low means inactive
  wire [`VDC_WORD_W-1:0] live_word = {sync,
                                      blank,
                                      force_full_scale,
                                      brighten,
                                      data_word};

  // convert_clock is a sampled level; a rising edge is a one-cycle
  // pulse here, so the capture lands one clk after the pin edge
  wire cvt_rise = convert_clock & ~cvt_prev;

  // pixel buffer
  wire                   fifo_in_ready;
  wire                   fifo_out_valid;
  wire [`VDC_WORD_W-1:0] fifo_out_data;
  wire [`VDC_FIFO_CW-1:0] fifo_count;
  wire                   cap_push;
  wire                   drain;

  // capture only in registered mode
  assign cap_push = cvt_rise & ~passthrough_select;
  // software hold stalls the drain so the buffer really fills
  assign drain    = ~drain_hold & ~passthrough_select;

  vdc_fifo #(
    .WIDTH (`VDC_WORD_W),
    .DEPTH (`VDC_FIFO_DEPTH),
    .AW    (`VDC_FIFO_AW),
    .CW    (`VDC_FIFO_CW)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (cap_push),
    .in_ready  (fifo_in_ready),
    .in_data   (live_word),
    .out_valid (fifo_out_valid),
    .out_ready (drain),
    .out_data  (fifo_out_data),
    .count     (fifo_count)
  );

  wire fifo_pop = drain & fifo_out_valid;

  // word that feeds the decode
  reg [`VDC_WORD_W-1:0] next_held;

  always @* begin
    if (passthrough_select) begin
      // bypass: follow the pins every clk, no convert edge needed
      next_held = live_word;
    end else if (fifo_pop) begin
      next_held = fifo_out_data;
    end else begin
      next_held = held;
    end
  end

  // priority decode
  wire                   w_sync   = next_held[`VDC_W_SYNC];
  wire                   w_blank  = next_held[`VDC_W_BLANK];
  wire                   w_ffs    = next_held[`VDC_W_FFS];
  wire                   w_bright = next_held[`VDC_W_BRIGHT];
  wire [`VDC_DATA_W-1:0] w_data   = next_held[`VDC_DATA_W-1:0];

  // sync beats everything, blank beats data and the rest
  wire                   lvl_active = ~w_sync & ~w_blank;
  reg  [`VDC_DATA_W-1:0] eff_code;

  always @* begin
    if (!lvl_active) begin
      eff_code = `VDC_CODE_ZERO;
    end else if (w_ffs) begin
      eff_code = `VDC_FULL_SCALE;
    end else begin
      eff_code = w_data;
    end
  end

  // brighten is one extra sink worth a tenth of full scale
  wire next_bright = lvl_active & w_bright;
  // blank sink carries the pedestal; sync adds its own on top
  wire next_blank  = ~lvl_active;
  wire next_sync   = w_sync;

  // segmented decode
  wire [3:0]              upper = eff_code[7:4];
  wire [`VDC_THERM_N-1:0] next_therm;

  // fifteen equal sinks: segment i is on when the nibble exceeds i
  genvar gi;
  generate
    for (gi = 0; gi < `VDC_THERM_N; gi = gi + 1) begin : g_therm
      assign next_therm[gi] = (upper > gi);
    end
  endgenerate

  wire [`VDC_BIN_N-1:0] next_bin = eff_code[3:0];

  // datapath registers
  always @(posedge clk) begin
    if (reset) begin
      cvt_prev    <= 1'b0;
      held        <= {`VDC_WORD_W{1'b0}};
      sink_therm  <= {`VDC_THERM_N{1'b0}};
      sink_bin    <= {`VDC_BIN_N{1'b0}};
      sink_blank  <= 1'b0;
      sink_sync   <= 1'b0;
      sink_bright <= 1'b0;
      pixel_ready <= 1'b0;
      pass_active <= 1'b0;
    end else begin
      cvt_prev    <= convert_clock;
      held        <= next_held;
      // the analog stage sums these with no further gating
      sink_therm  <= next_therm;
      sink_bin    <= next_bin;
      sink_blank  <= next_blank;
      sink_sync   <= next_sync;
      sink_bright <= next_bright;
      pixel_ready <= fifo_in_ready;
      pass_active <= passthrough_select;
    end
  end

  // control and sticky status
  // a capture against a full buffer is dropped and flagged
  wire ovf_event = cap_push & ~fifo_in_ready;

  always @(posedge clk) begin
    if (reset) begin
      drain_hold <= `VDC_CTRL_RST;
      overflow   <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        drain_hold <= avs_writedata[`VDC_CTRL_HOLD];
      end
      // set wins over a write-one clear in the same cycle
      if (ovf_event) begin
        overflow <= 1'b1;
      end else if (wr_status && avs_writedata[`VDC_ST_OVF]) begin
        overflow <= 1'b0;
      end
    end
  end

  // read mux
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `VDC_REG_CTRL: begin
        rd_mux[`VDC_CTRL_HOLD] = drain_hold;
      end
      `VDC_REG_STATUS: begin
        rd_mux[`VDC_ST_OVF]   = overflow;
        rd_mux[`VDC_ST_PASS]  = passthrough_select;
        rd_mux[`VDC_ST_EMPTY] = ~fifo_out_valid;
        rd_mux[`VDC_ST_FULL]  = ~fifo_in_ready;
        rd_mux[`VDC_ST_COUNT_HI:`VDC_ST_COUNT_LO] = fifo_count;
      end
      `VDC_REG_SAMPLE: begin
        rd_mux[`VDC_WORD_W-1:0] = held;
      end
      `VDC_REG_SINKS: begin
        rd_mux[`VDC_SK_THERM_HI:`VDC_SK_THERM_LO] = sink_therm;
        rd_mux[`VDC_SK_BIN_HI:`VDC_SK_BIN_LO]     = sink_bin;
        rd_mux[`VDC_SK_BLANK]  = sink_blank;
        rd_mux[`VDC_SK_SYNC]   = sink_sync;
        rd_mux[`VDC_SK_BRIGHT] = sink_bright;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // bus response registers
  // waitrequest idles high; drops for exactly one cycle per request so
  // read data is registered before the master samples it
  always @(posedge clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      if (bus_req && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end else if (bus_take) begin
        avs_readdata <= avs_readdata;
      end
    end
  end

endmodule // vdc_top

// ===== hw/vdc_defs.vh
// vdc_defs.vh: constants for the video DAC input control and decode block.
// assumes it is included by bare name from every design file that needs it.
`ifndef VDC_DEFS_VH
`define VDC_DEFS_VH

// data word and captured word layout
`define VDC_DATA_W        8
`define VDC_WORD_W        12
`define VDC_W_SYNC        11
`define VDC_W_BLANK       10
`define VDC_W_FFS         9
`define VDC_W_BRIGHT      8
`define VDC_FULL_SCALE    8'hff
`define VDC_CODE_ZERO     8'h00

// segmented sinks: upper nibble as thermometer, lower nibble binary
`define VDC_THERM_N       15
`define VDC_BIN_N         4

// pixel buffer
`define VDC_FIFO_DEPTH    8
`define VDC_FIFO_AW       3
`define VDC_FIFO_CW       4

// register bus
`define VDC_ADDR_W        4
`define VDC_REG_CTRL      4'h0
`define VDC_REG_STATUS    4'h4
`define VDC_REG_SAMPLE    4'h8
`define VDC_REG_SINKS     4'hc

// control register fields
`define VDC_CTRL_HOLD     0
`define VDC_CTRL_RST      1'b0

// status register fields
`define VDC_ST_OVF        0
`define VDC_ST_PASS       1
`define VDC_ST_EMPTY      2
`define VDC_ST_FULL       3
`define VDC_ST_COUNT_LO   4
`define VDC_ST_COUNT_HI   7

// sinks register fields
`define VDC_SK_THERM_LO   0
`define VDC_SK_THERM_HI   14
`define VDC_SK_BIN_LO     15
`define VDC_SK_BIN_HI     18
`define VDC_SK_BLANK      19
`define VDC_SK_SYNC       20
`define VDC_SK_BRIGHT     21

`endif

// ===== hw/vdc_fifo.v
// vdc_fifo.v: small synchronous FIFO holding captured pixel words.
// assumes one clock, synchronous active-high reset, registered read data.
`timescale 1ns/1ps

module vdc_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 8,
  parameter AW    = 3,
  parameter CW    = 4
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data,
  output reg  [CW-1:0]    count
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg             full;
  reg             empty;

  wire          push = in_valid & ~full;
  wire          pop  = out_ready & ~empty;
  wire [AW-1:0] next_rd = pop ? rd_ptr + 1'b1 : rd_ptr;
  wire [CW-1:0] next_count = count + {{(CW-1){1'b0}}, push}
                             - {{(CW-1){1'b0}}, pop};

  assign in_ready  = ~full;
  assign out_valid = ~empty;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // head register; a word written into the slot about to be read
  // bypasses the array so the head never goes stale
  always @(posedge clk) begin
    if (reset) begin
      out_data <= {WIDTH{1'b0}};
    end else if (push && (wr_ptr == next_rd)) begin
      out_data <= in_data;
    end else begin
      out_data <= mem[next_rd];
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {CW{1'b0}};
      full   <= 1'b0;
      empty  <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      rd_ptr <= next_rd;
      count  <= next_count;
      full   <= (next_count == DEPTH[CW-1:0]);
      empty  <= (next_count == {CW{1'b0}});
    end
  end

endmodule // vdc_fifo

// ===== test/vdc_props.sv
// vdc_props.sv: port properties of the video DAC decode front end.
// assumes it is bound to vdc_top; one clock, synchronous reset.
`timescale 1ns/1ps
module vdc_props (
  input logic        clk,
  input logic        reset,
  input logic        passthrough_select,
  input logic        pass_active,
  input logic [7:0]  data_word,
  input logic        sync,
  input logic        blank,
  input logic        force_full_scale,
  input logic        brighten,
  input logic [14:0] sink_therm,
  input logic [3:0]  sink_bin,
  input logic        sink_blank,
  input logic        sink_sync,
  input logic        sink_bright
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  function automatic logic [18:0] level(input logic [7:0] c);
    return {15'h7fff >> (4'hf - c[7:4]), c[3:0]};
  endfunction
  // both mode flags high, so either one may steer the design
  sequence s_pass; passthrough_select && pass_active; endsequence
  sequence s_open; s_pass ##0 !sync && !blank; endsequence
  property p_mode; 1'b1 |=> pass_active == $past(passthrough_select);
  endproperty
  a_mode: assert property (p_mode) else $error("mode flag lags");
  property p_sync; s_pass |=> sink_sync == $past(sync);
  endproperty
  a_sync: assert property (p_sync) else $error("sync not followed");
  property p_blank; s_pass |=> sink_blank == ($past(sync) || $past(blank));
  endproperty
  a_blank: assert property (p_blank) else $error("blank wrong");
  property p_data; s_open ##0 !force_full_scale |=>
    {sink_therm, sink_bin} == level($past(data_word));
  endproperty
  a_data: assert property (p_data) else $error("data level wrong");
  property p_full; s_open ##0 force_full_scale |=>
    {sink_therm, sink_bin} == 19'h7ffff;
  endproperty
  a_full: assert property (p_full) else $error("full scale wrong");
  property p_bright; s_pass |=>
    sink_bright == ($past(brighten) && !$past(sync) && !$past(blank));
  endproperty
  a_bright: assert property (p_bright) else $error("bright wrong");
  property p_zero;
    sink_blank |-> !sink_bright && {sink_therm, sink_bin} == 19'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("blank not empty");
  property p_over; sink_sync |-> sink_blank;
  endproperty
  a_over: assert property (p_over) else $error("sync lacks blank");
  property p_therm; ((sink_therm + 15'h1) & sink_therm) == 15'h0;
  endproperty
  a_therm: assert property (p_therm) else $error("not thermometer");
endmodule // vdc_props

bind vdc_top vdc_props u_props (
  .clk(clk), .reset(reset), .passthrough_select(passthrough_select),
  .pass_active(pass_active), .data_word(data_word), .sync(sync),
  .blank(blank), .force_full_scale(force_full_scale),
  .brighten(brighten), .sink_therm(sink_therm), .sink_bin(sink_bin),
  .sink_blank(sink_blank), .sink_sync(sink_sync),
  .sink_bright(sink_bright)
);

// ===== test/vdc_source.sv
// vdc_source.sv: pixel source standing in for a graphics controller.
// assumes its tasks are entered just after a rising clk edge.
`timescale 1ns/1ps
module vdc_source (
  input  logic       clk,
  output logic       convert_clock,
  output logic       passthrough_select,
  output logic [7:0] data_word,
  output logic       sync,
  output logic       blank,
  output logic       force_full_scale,
  output logic       brighten
);
  initial begin
    convert_clock = 1'b0;
    passthrough_select = 1'b0;
    {sync, blank, force_full_scale, brighten, data_word} = 12'h000;
  end
  task automatic put(input logic [11:0] w);
    {sync, blank, force_full_scale, brighten, data_word} <= w;
  endtask
  // mode is a static setting, changed only between pixels
  task automatic set_mode(input logic p);
    passthrough_select <= p;
    repeat (2) @(posedge clk);
  endtask
  task automatic capture(input logic [11:0] w);
    put(w);
    convert_clock <= 1'b0;
    @(posedge clk);
    convert_clock <= 1'b1;
    @(posedge clk);
    convert_clock <= 1'b0;
    // hold time over: lines no longer carry the pixel
    put(~w);
    @(posedge clk);
  endtask
endmodule // vdc_source

// ===== test/test_video_dac_input_control_decode.sv
// test_video_dac_input_control_decode.sv: self-checking bench, vdc_top.
// assumes vdc_source drives the pixel side; bench owns bus and reset.
`timescale 1ns/1ps
module test_video_dac_input_control_decode;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  adr = 4'h0;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd;
  wire  [31:0] rdat;
  wire  [7:0]  dw;
  wire  [14:0] k_th;
  wire  [3:0]  k_bi;
  wire         wreq, cv, ps, sy, bl, ffs, bri, rdy, pa, k_bl, k_sy, k_br;
  int          errors = 0;
  int          checked = 0;
  always #4 clk = ~clk;
  vdc_top DUT (
    .clk(clk), .reset(reset), .avs_address(adr), .avs_read(rd_en),
    .avs_write(wr_en), .avs_writedata(wdat), .avs_byteenable(4'hf),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .convert_clock(cv),
    .passthrough_select(ps), .data_word(dw), .sync(sy), .blank(bl),
    .force_full_scale(ffs), .brighten(bri), .pixel_ready(rdy),
    .pass_active(pa), .sink_therm(k_th), .sink_bin(k_bi),
    .sink_blank(k_bl), .sink_sync(k_sy), .sink_bright(k_br)
  );
  vdc_source SRC (
    .clk(clk), .convert_clock(cv), .passthrough_select(ps),
    .data_word(dw), .sync(sy), .blank(bl), .force_full_scale(ffs),
    .brighten(bri)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    adr <= a;
    wr_en <= wr;
    rd_en <= !wr;
    wdat <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (wreq !== 1'b0) begin
      errors++;
      end_sim();
    end
    rd = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] sinks();
    return {10'h0, k_br, k_sy, k_bl, k_bi, k_th};
  endfunction
  function automatic logic [31:0] lvl(input logic [11:0] w);
    logic [7:0] c;
    c = (w[11] | w[10]) ? 8'h00 : (w[9] ? 8'hff : w[7:0]);
    return {10'h0, w[8] & !w[11] & !w[10], w[11], w[11] | w[10],
            c[3:0], 15'h7fff >> (4'hf - c[7:4])};
  endfunction
  task automatic t_regs;
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h4);
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_pass;
    logic [11:0] tbl [8] = '{12'hfff, 12'h7ff, 12'h3a5, 12'h2a5,
                             12'h100, 12'h0ff, 12'h000, 12'h05a};
    SRC.set_mode(1'b1);
    foreach (tbl[i]) begin
      SRC.put(tbl[i]);
      repeat (2) @(posedge clk);
      chk(sinks(), lvl(tbl[i]));
    end
    bus(1'b0, 4'hc, 32'h0);
    chk(rd, lvl(12'h05a));
    bus(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h6);
  endtask
  task automatic t_reg;
    SRC.set_mode(1'b0);
    // live word changes with no convert edge; sinks must hold
    SRC.put(12'h0f0);
    repeat (3) @(posedge clk);
    chk(sinks(), lvl(12'h05a));
    // sinks load at the pop edge, the last edge inside capture
    SRC.capture(12'h1c3);
    @(posedge clk);
    chk(sinks(), lvl(12'h1c3));
    // live lines now carry the inverse word; sinks must not follow
    repeat (4) @(posedge clk);
    chk(sinks(), lvl(12'h1c3));
    bus(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h1c3);
  endtask
  task automatic t_fill;
    bus(1'b1, 4'h0, 32'h1);
    for (int i = 0; i < 9; i++) SRC.capture({4'h0, 8'(i * 17)});
    bus(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h89);
    chk({31'h0, rdy}, 32'h0);
    bus(1'b1, 4'h4, 32'h1);
    bus(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h88);
    bus(1'b1, 4'h0, 32'h0);
    for (int n = 0; n < 20 && rd[2] !== 1'b1; n++) bus(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h4);
    if (rd[2] !== 1'b1) end_sim();
    bus(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h077);
    chk(sinks(), lvl(12'h077));
    chk({31'h0, rdy}, 32'h1);
  endtask
  task automatic t_rerun;
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk(sinks(), 32'h0);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h0);
  endtask
  initial begin
    #400000;
    errors++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs();
    t_pass();
    t_reg();
    t_fill();
    t_rerun();
    end_sim();
  end
endmodule // test_video_dac_input_control_decode
